// *** design/render_params.svh ***
// Offsets, field positions, codes and reset values of the render command registers.
//
// Behaviour
// - Depth stride bits 11-0, low three zero
// - Texture base bits 21-3, quadword aligned
// - No wrap and outside: border colour used
// - Border bytes used according to texel format
// - Fog enable blends fog colour by alpha
// - Four-bit blend texels interpolate between two limits
// - Launch on command write or last parameter
// - Auto-execute off with NOP launches nothing
// - Clipping active only while bit 1 set
// - Target pixel format codes, others reserved
// - Texel format codes in bits 7-5
// - Mipmap size at most nine
// - Filter codes; video only with YUV; 111 reserved
// - Texture blend reflect, modulate, decal
// - Alpha blend off, texture or source alpha
// - Depth compare never, relations, always
// - Depth written only when compare passes
// - Depth buffering modes, 11 means none
// - Draw command codes, others reserved
// - Bit 31 reads one while 3D executes
// - Scan-line count write launches line set
`ifndef RENDER_PARAMS_SVH
`define RENDER_PARAMS_SVH

`define ADR_FOG 16'hb0f4
`define ADR_LCMD 16'hb100
`define ADR_LGBD 16'hb144
`define ADR_LYCNT 16'hb17c
`define ADR_ZSTR_L 16'hb0e8
`define ADR_ZSTR_T 16'hb4e8
`define ADR_TBASE 16'hb4ec
`define ADR_BDR 16'hb4f0
`define ADR_C0 16'hb4f8
`define ADR_C1 16'hb4fc
`define ADR_TCMD 16'hb500
`define ADR_TLAUNCH 16'hb57c
`define ADR_STATUS 16'hb0f8

`define NREG 11
`define IX_FOG 4'h0
`define IX_LCMD 4'h1
`define IX_LGBD 4'h2
`define IX_LYCNT 4'h3
`define IX_ZSTR 4'h4
`define IX_TBASE 4'h5
`define IX_BDR 4'h6
`define IX_C0 4'h7
`define IX_C1 4'h8
`define IX_TCMD 4'h9
`define IX_TLAUNCH 4'ha

`define MSK_COLOUR 32'h00ff_ffff
`define MSK_ZSTR 32'h0000_0ff8
`define MSK_TBASE 32'h003f_fff8
`define MSK_CMD 32'h7fff_ffff
`define MSK_YCNT 32'h8000_07ff
`define MSK_FULL 32'hffff_ffff
`define RST_REG 32'h0000_0000
`define RST_CMD 32'h7800_0000

`define ST_BUSY 0
`define ST_FAULT 1

`define CMD_GOURAUD 4'h0
`define CMD_LIT 4'h1
`define CMD_UNLIT 4'h2
`define CMD_LIT_PERSP 4'h5
`define CMD_UNLIT_PERSP 4'h6
`define CMD_LINE 4'h8
`define CMD_NOP 4'hf

`define DEST_FMT_MAX 3'h2
`define TEX_FMT_8888 3'h0
`define TEX_FMT_4444 3'h1
`define TEX_FMT_1555 3'h2
`define TEX_FMT_A4B4 3'h3
`define TEX_FMT_B4LO 3'h4
`define TEX_FMT_B4HI 3'h5
`define TEX_FMT_PAL 3'h6
`define TEX_FMT_YUV 3'h7
`define MIP_MAX 4'h9
`define FLT_MIP_NEAREST 3'h0
`define FLT_NEAREST 3'h4
`define FLT_VIDEO 3'h5
`define FLT_RSVD 3'h7
`define TXB_REFLECT 2'h0
`define TXB_MODULATE 2'h1
`define TXB_DECAL 2'h2
`define TXB_RSVD 2'h3
`define ALPHA_SRC 2'h3
`define ZB_DRAW_PASS 2'h2
`define ZB_NONE 2'h3

`define ZC_NEVER 3'h0
`define ZC_GT 3'h1
`define ZC_EQ 3'h2
`define ZC_GE 3'h3
`define ZC_LT 3'h4
`define ZC_NE 3'h5
`define ZC_LE 3'h6
`define ZC_ALWAYS 3'h7

`endif

// *** design/render_pkg.sv ***
// Types shared by the render command register block.
package render_pkg;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic dimension_select;
      logic [3:0] draw_command;
      logic texture_wrap_enable;
      logic [1:0] depth_buffering_mode;
      logic depth_update_enable;
      logic [2:0] depth_compare_mode;
      logic [1:0] alpha_blend_control;
      logic fog_enable;
      logic [1:0] texture_blend_mode;
      logic [2:0] texel_filter_mode;
      logic [3:0] mipmap_size;
      logic [2:0] texel_format;
      logic [2:0] target_pixel_format;
      logic hw_clip_enable;
      logic auto_execute;
   } cmd_cfg_s;

   typedef enum logic [0:0] {EXEC_IDLE, EXEC_3D} exec_state_e;

endpackage

// *** design/render_depth_test.sv ***
// Depth compare and depth write decision for one pixel.
`timescale 1ns/1ps
`default_nettype none
`include "render_params.svh"
module render_depth_test (
   input wire logic [2:0] compare_mode,
   input wire logic update_enable,
   input wire logic [1:0] buffering_mode,
   input wire logic [15:0] zs,
   input wire logic [15:0] zzb,
   output logic pass,
   output logic write
);
   logic cmp;

   always_comb
   begin
      case (compare_mode)
         `ZC_NEVER: cmp = 1'b0;
         `ZC_GT: cmp = zs > zzb;
         `ZC_EQ: cmp = zs == zzb;
         `ZC_GE: cmp = zs >= zzb;
         `ZC_LT: cmp = zs < zzb;
         `ZC_NE: cmp = zs != zzb;
         `ZC_LE: cmp = zs <= zzb;
         default: cmp = 1'b1;
      endcase
   end

   // Without depth buffering every pixel passes and nothing is stored.
   assign pass = (buffering_mode == `ZB_NONE) ? 1'b1 : cmp;
   assign write = update_enable & cmp & (buffering_mode != `ZB_NONE)
                  & (buffering_mode != `ZB_DRAW_PASS);
endmodule
`default_nettype wire

// *** design/render_engine_command_regs.sv ***
// Render engine parameter and command registers with launch control and pixel colouring.
`timescale 1ns/1ps
`default_nettype none
`include "render_params.svh"
module render_engine_command_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire render_pkg::wb_req_s wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic engine_done,
   output logic launch_o,
   output logic launch_line_o,
   output render_pkg::cmd_cfg_s active_cfg_o,
   output logic [11:0] depth_stride_o,
   output logic [21:0] texture_base_o,
   output logic [10:0] line_count_o,
   output logic line_dir_o,
   output logic clip_enable_o,
   output logic alpha_blend_enable_o,
   output logic alpha_use_source_o,
   input wire logic pix_valid_i,
   input wire logic [23:0] texel_rgb_i,
   input wire logic texel_outside_i,
   input wire logic [3:0] blend_weight_i,
   input wire logic [23:0] pixel_rgb_i,
   input wire logic [7:0] source_alpha_i,
   input wire logic [15:0] zs_i,
   input wire logic [15:0] zzb_i,
   output logic colour_valid_o,
   output logic [23:0] colour_o,
   output logic depth_pass_o,
   output logic depth_write_o
);
   import render_pkg::*;

   logic req;
   logic ack_r;
   logic [31:0] rdat_r;
   logic wr_now;
   logic hit;
   logic st_hit;
   logic [3:0] idx;
   logic [31:0] regs_r [0:`NREG-1];
   logic [31:0] wmerged;
   logic [31:0] rd_mux;
   exec_state_e exec_r;
   logic fault_r;
   cmd_cfg_s active_r;
   cmd_cfg_s lcmd;
   cmd_cfg_s tcmd;
   cmd_cfg_s wcmd;
   logic wr_lcmd;
   logic wr_tcmd;
   logic wr_ycnt;
   logic wr_tl;
   logic go_line;
   logic go_tri;
   logic go_cfg_bad;
   cmd_cfg_s go_cfg;
   logic [23:0] bdr_m;
   logic [23:0] chan_out;
   logic z_pass;
   logic z_write;
   logic colour_valid_r;
   logic [23:0] colour_r;
   logic depth_pass_r;
   logic depth_write_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] mask_of(input logic [3:0] i);
      case (i)
         `IX_FOG, `IX_BDR, `IX_C0, `IX_C1: mask_of = `MSK_COLOUR;
         `IX_LCMD, `IX_TCMD: mask_of = `MSK_CMD;
         `IX_ZSTR: mask_of = `MSK_ZSTR;
         `IX_TBASE: mask_of = `MSK_TBASE;
         `IX_LYCNT: mask_of = `MSK_YCNT;
         default: mask_of = `MSK_FULL;
      endcase
   endfunction

   function automatic logic [31:0] reset_of(input logic [3:0] i);
      if (i == `IX_LCMD || i == `IX_TCMD)
      begin
         reset_of = `RST_CMD;
      end
      else
      begin
         reset_of = `RST_REG;
      end
   endfunction

   function automatic logic runnable(input logic [3:0] c);
      case (c)
         `CMD_GOURAUD, `CMD_LIT, `CMD_UNLIT, `CMD_LIT_PERSP, `CMD_UNLIT_PERSP, `CMD_LINE: runnable = 1'b1;
         default: runnable = 1'b0;
      endcase
   endfunction

   // Flags any reserved or disallowed setting in a command that is launched.
   function automatic logic cfg_bad(input cmd_cfg_s c);
      logic pal_bad;
      pal_bad = (c.texel_format == `TEX_FMT_PAL)
                & (((c.texel_filter_mode != `FLT_MIP_NEAREST) & (c.texel_filter_mode != `FLT_NEAREST))
                   | (c.texture_blend_mode != `TXB_DECAL));
      cfg_bad = (c.target_pixel_format > `DEST_FMT_MAX) | (c.mipmap_size > `MIP_MAX)
                | (c.texel_filter_mode == `FLT_RSVD) | (c.texture_blend_mode == `TXB_RSVD)
                | ((c.texel_filter_mode == `FLT_VIDEO) & (c.texel_format != `TEX_FMT_YUV))
                | pal_bad;
   endfunction

   // Border bytes that the texel format actually uses; the rest read as zero.
   function automatic logic [23:0] border_mask(input logic [2:0] f);
      case (f)
         `TEX_FMT_PAL: border_mask = 24'h0000ff;
         `TEX_FMT_4444, `TEX_FMT_1555, `TEX_FMT_YUV: border_mask = 24'h00ffff;
         default: border_mask = 24'hffffff;
      endcase
   endfunction

   assign req = wb_req.cyc & wb_req.stb;
   assign wr_now = req & ack_r & wb_req.we;

   always_comb
   begin
      hit = 1'b1;
      st_hit = 1'b0;
      idx = `IX_FOG;
      case (wb_req.adr[15:0])
         `ADR_FOG: idx = `IX_FOG;
         `ADR_LCMD: idx = `IX_LCMD;
         `ADR_LGBD: idx = `IX_LGBD;
         `ADR_LYCNT: idx = `IX_LYCNT;
         `ADR_ZSTR_L, `ADR_ZSTR_T: idx = `IX_ZSTR;
         `ADR_TBASE: idx = `IX_TBASE;
         `ADR_BDR: idx = `IX_BDR;
         `ADR_C0: idx = `IX_C0;
         `ADR_C1: idx = `IX_C1;
         `ADR_TCMD: idx = `IX_TCMD;
         `ADR_TLAUNCH: idx = `IX_TLAUNCH;
         `ADR_STATUS:
         begin
            hit = 1'b0;
            st_hit = 1'b1;
         end
         default: hit = 1'b0;
      endcase
   end

   assign wmerged = merge(regs_r[idx], wb_req.dat, wb_req.sel) & mask_of(idx);

   // Register storage; reserved bits and aligned address bits are kept at zero.
   for (genvar g = 0; g < `NREG; g++)
   begin : g_reg
      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            regs_r[g] <= reset_of(4'(g));
         end
         else if (wr_now && hit && idx == 4'(g))
         begin
            regs_r[g] <= wmerged;
         end
      end
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (st_hit)
      begin
         rd_mux[`ST_BUSY] = (exec_r == EXEC_3D);
         rd_mux[`ST_FAULT] = fault_r;
      end
      else if (hit)
      begin
         rd_mux = regs_r[idx];
         if (idx == `IX_LCMD || idx == `IX_TCMD)
         begin
            rd_mux[31] = (exec_r == EXEC_3D);
         end
      end
   end

   // One wait state: ack follows the request by one cycle and drops after one.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (req && !ack_r && !wb_req.we)
         begin
            rdat_r <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   assign lcmd = cmd_cfg_s'(regs_r[`IX_LCMD]);
   assign tcmd = cmd_cfg_s'(regs_r[`IX_TCMD]);
   assign wcmd = cmd_cfg_s'(wmerged);
   assign wr_lcmd = wr_now & hit & (idx == `IX_LCMD);
   assign wr_tcmd = wr_now & hit & (idx == `IX_TCMD);
   assign wr_ycnt = wr_now & hit & (idx == `IX_LYCNT);
   assign wr_tl = wr_now & hit & (idx == `IX_TLAUNCH);

   // A NOP or reserved code never launches, whatever the launch path.
   assign go_line = (wr_lcmd & ~wcmd.auto_execute & runnable(wcmd.draw_command))
                    | (wr_ycnt & lcmd.auto_execute & runnable(lcmd.draw_command));
   assign go_tri = (wr_tcmd & ~wcmd.auto_execute & runnable(wcmd.draw_command))
                   | (wr_tl & tcmd.auto_execute & runnable(tcmd.draw_command));
   assign go_cfg = (wr_lcmd | wr_tcmd) ? wcmd : (wr_ycnt ? lcmd : tcmd);
   assign go_cfg_bad = ((go_line | go_tri) & cfg_bad(go_cfg))
                       | ((wr_lcmd | wr_tcmd) & ~wcmd.auto_execute & ~runnable(wcmd.draw_command)
                          & (wcmd.draw_command != `CMD_NOP));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         launch_o <= 1'b0;
         launch_line_o <= 1'b0;
         active_r <= cmd_cfg_s'(`RST_CMD);
      end
      else
      begin
         launch_o <= go_line | go_tri;
         launch_line_o <= go_line;
         if (go_line || go_tri)
         begin
            active_r <= go_cfg;
            active_r.dimension_select <= 1'b1;
         end
      end
   end

   // A launch in the same cycle as engine_done keeps the engine marked busy.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         exec_r <= EXEC_IDLE;
      end
      else if (go_line || go_tri)
      begin
         exec_r <= EXEC_3D;
      end
      else if (engine_done)
      begin
         exec_r <= EXEC_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fault_r <= 1'b0;
      end
      else if (go_cfg_bad)
      begin
         fault_r <= 1'b1;
      end
      else if (wr_now && st_hit && wb_req.sel[0] && wb_req.dat[`ST_FAULT])
      begin
         fault_r <= 1'b0;
      end
   end

   assign active_cfg_o = active_r;
   assign depth_stride_o = regs_r[`IX_ZSTR][11:0];
   assign texture_base_o = regs_r[`IX_TBASE][21:0];
   assign line_count_o = regs_r[`IX_LYCNT][10:0];
   assign line_dir_o = regs_r[`IX_LYCNT][31];
   assign clip_enable_o = active_r.hw_clip_enable;
   assign alpha_blend_enable_o = active_r.alpha_blend_control[1];
   assign alpha_use_source_o = (active_r.alpha_blend_control == `ALPHA_SRC);

   assign bdr_m = regs_r[`IX_BDR][23:0] & border_mask(active_r.texel_format);

   // Per colour channel: texel source, four-bit blend interpolation, texture blend, fog.
   for (genvar c = 0; c < 3; c++)
   begin : g_chan
      logic [7:0] tex;
      logic [7:0] tsel;
      logic [7:0] pix;
      logic [7:0] comb;
      logic [13:0] lerp;
      logic [15:0] prod;
      logic [8:0] sum;
      logic [16:0] fog;
      logic [4:0] w_lo;
      logic interp;

      assign pix = pixel_rgb_i[c*8 +: 8];
      assign tex = (!active_r.texture_wrap_enable && texel_outside_i) ? bdr_m[c*8 +: 8]
                   : texel_rgb_i[c*8 +: 8];
      assign w_lo = 5'h10 - {1'b0, blend_weight_i};
      assign lerp = ({6'h00, regs_r[`IX_C0][c*8 +: 8]} * {9'h000, w_lo})
                    + ({6'h00, regs_r[`IX_C1][c*8 +: 8]} * {10'h000, blend_weight_i});
      assign interp = (active_r.texel_format == `TEX_FMT_A4B4) | (active_r.texel_format == `TEX_FMT_B4LO)
                      | (active_r.texel_format == `TEX_FMT_B4HI);
      assign tsel = (interp && !(!active_r.texture_wrap_enable && texel_outside_i)) ? lerp[11:4] : tex;
      assign prod = tsel * pix;
      assign sum = {1'b0, tsel} + {1'b0, pix};

      always_comb
      begin
         case (active_r.texture_blend_mode)
            `TXB_REFLECT: comb = sum[8] ? 8'hff : sum[7:0];
            `TXB_MODULATE: comb = prod[15:8];
            default: comb = tsel;
         endcase
      end

      assign fog = ({9'h000, comb} * {9'h000, 8'hff - source_alpha_i})
                   + ({9'h000, regs_r[`IX_FOG][c*8 +: 8]} * {9'h000, source_alpha_i});
      assign chan_out[c*8 +: 8] = active_r.fog_enable ? fog[15:8] : comb;
   end

   render_depth_test render_depth_test_inst (
      .compare_mode(active_r.depth_compare_mode),
      .update_enable(active_r.depth_update_enable),
      .buffering_mode(active_r.depth_buffering_mode),
      .zs(zs_i),
      .zzb(zzb_i),
      .pass(z_pass),
      .write(z_write)
   );

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         colour_valid_r <= 1'b0;
         colour_r <= 24'h000000;
         depth_pass_r <= 1'b0;
         depth_write_r <= 1'b0;
      end
      else
      begin
         colour_valid_r <= pix_valid_i;
         if (pix_valid_i)
         begin
            colour_r <= chan_out;
            depth_pass_r <= z_pass;
            depth_write_r <= z_write;
         end
      end
   end

   assign colour_valid_o = colour_valid_r;
   assign colour_o = colour_r;
   assign depth_pass_o = depth_pass_r;
   assign depth_write_o = depth_write_r;

   AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      req && !ack_r |=> ack_r ##1 !ack_r) else $error("ack not a single pulse");
   AST_STRIDE_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
      depth_stride_o[2:0] == 3'h0) else $error("depth stride low bits set");
   AST_TBASE_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
      texture_base_o[2:0] == 3'h0) else $error("texture base low bits set");
   AST_CMD_LAUNCH: assert property (@(posedge clk) disable iff (!rst_n)
      wr_lcmd && !wcmd.auto_execute && wcmd.draw_command == `CMD_LINE |=> launch_o && launch_line_o)
      else $error("command write did not launch");
   AST_AUTO_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
      wr_tcmd && wcmd.auto_execute && !wr_tl |=> !launch_o) else $error("auto-execute launched early");
   AST_NOP_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_lcmd || wr_tcmd) && wcmd.draw_command == `CMD_NOP |=> !launch_o) else $error("NOP launched");
   AST_YCNT_LAUNCH: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ycnt && lcmd.auto_execute && runnable(lcmd.draw_command) |=> launch_line_o && launch_o)
      else $error("scan-line count write did not launch");
   AST_BUSY_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      launch_o |-> exec_r == EXEC_3D && active_r.dimension_select) else $error("3D busy not shown");
   AST_BORDER_USED: assert property (@(posedge clk) disable iff (!rst_n)
      pix_valid_i && !active_r.texture_wrap_enable && texel_outside_i && !active_r.fog_enable
      && active_r.texel_format == `TEX_FMT_8888 && active_r.texture_blend_mode == `TXB_DECAL
      |=> colour_o == $past(regs_r[`IX_BDR][23:0])) else $error("border colour not used");
   AST_DEPTH_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      colour_valid_o && depth_write_o |-> depth_pass_o) else $error("depth written on failed test");
   AST_NO_ZBUF: assert property (@(posedge clk) disable iff (!rst_n)
      pix_valid_i && active_r.depth_buffering_mode == `ZB_NONE |=> !depth_write_o && depth_pass_o)
      else $error("depth written without buffering");
endmodule
`default_nettype wire

// *** testbench/test_render_engine_command_regs.sv ***
// Self-checking bench for the render engine command registers.
`timescale 1ns/1ps
`default_nettype none
`include "render_params.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_render_engine_command_regs;
   import render_pkg::*;
   logic clk, rst_n, wb_ack_o, engine_done, launch_o, launch_line_o, line_dir_o, clip_enable_o;
   logic alpha_blend_enable_o, alpha_use_source_o, pix_valid_i, texel_outside_i;
   logic colour_valid_o, depth_pass_o, depth_write_o;
   wb_req_s wb_req;
   cmd_cfg_s active_cfg_o;
   logic [31:0] wb_dat_o;
   logic [11:0] depth_stride_o;
   logic [21:0] texture_base_o;
   logic [10:0] line_count_o;
   logic [23:0] texel_rgb_i, pixel_rgb_i, colour_o;
   logic [3:0] blend_weight_i;
   logic [7:0] source_alpha_i;
   logic [15:0] zs_i, zzb_i;
   int miscompares = 0;
   int samples_checked = 0;

   render_engine_command_regs render_engine_command_regs_inst (.clk(clk), .rst_n(rst_n), .wb_req(wb_req),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .engine_done(engine_done), .launch_o(launch_o),
      .launch_line_o(launch_line_o), .active_cfg_o(active_cfg_o), .depth_stride_o(depth_stride_o),
      .texture_base_o(texture_base_o), .line_count_o(line_count_o), .line_dir_o(line_dir_o),
      .clip_enable_o(clip_enable_o), .alpha_blend_enable_o(alpha_blend_enable_o),
      .alpha_use_source_o(alpha_use_source_o), .pix_valid_i(pix_valid_i), .texel_rgb_i(texel_rgb_i),
      .texel_outside_i(texel_outside_i), .blend_weight_i(blend_weight_i), .pixel_rgb_i(pixel_rgb_i),
      .source_alpha_i(source_alpha_i), .zs_i(zs_i), .zzb_i(zzb_i), .colour_valid_o(colour_valid_o),
      .colour_o(colour_o), .depth_pass_o(depth_pass_o), .depth_write_o(depth_write_o));

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic [15:0] a, input logic we, input logic [31:0] v, output logic [31:0] rd);
      int n;
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {16'h0000, a}, sel: 4'hf, dat: v};
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (wb_ack_o === 1'b1)
            break;
      end
      rd = wb_dat_o;
      wb_req <= '0;
      if (n == 20)
      begin
         miscompares++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic [31:0] d;
      bus(a, 1'b1, v, d);
   endtask

   task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] ex);
      logic [31:0] d;
      bus(a, 1'b0, 32'h0, d);
      `CHK(nm, ex, d)
   endtask

   task automatic launch_chk(input logic l, input logic ln);
      @(posedge clk);
      `CHK("launch_o", l, launch_o)
      if (l)
         `CHK("launch_line_o", ln, launch_line_o)
   endtask

   task automatic pix(input logic o, input logic [23:0] t, input logic [7:0] a, input logic [15:0] zs,
                      input logic [15:0] zz);
      @(posedge clk);
      pix_valid_i <= 1'b1;
      texel_outside_i <= o;
      texel_rgb_i <= t;
      source_alpha_i <= a;
      zs_i <= zs;
      zzb_i <= zz;
      @(posedge clk);
      pix_valid_i <= 1'b0;
      @(posedge clk);
      `CHK("colour_valid_o", 1'b1, colour_valid_o)
   endtask

   function automatic logic [31:0] cmd(input logic [3:0] code, input logic [2:0] zc, input logic zw,
                                       input logic fg, input logic cl, input logic ax, input logic [1:0] al);
      return {1'b0, code, 1'b0, 2'b00, zw, zc, al, fg, 2'b10, 3'h0, 4'h0, 3'h0, 3'h0, cl, ax};
   endfunction

   function automatic logic zpass(input logic [2:0] c, input logic [15:0] s, input logic [15:0] z);
      case (c)
         3'h0: return 1'b0;
         3'h1: return s > z;
         3'h2: return s == z;
         3'h3: return s >= z;
         3'h4: return s < z;
         3'h5: return s != z;
         3'h6: return s <= z;
         default: return 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] fogc(input logic [7:0] c, input logic [7:0] f, input logic [7:0] a);
      logic [16:0] s;
      s = 17'(c) * 17'(8'hff - a) + 17'(f) * 17'(a);
      return s[15:8];
   endfunction

   task automatic masks();
      logic [15:0] adr [7] = '{16'hb0f4, 16'hb0e8, 16'hb4ec, 16'hb4f0, 16'hb4f8, 16'hb4fc, 16'hb144};
      logic [31:0] msk [7] = '{32'h00ff_ffff, 32'h0000_0ff8, 32'h003f_fff8, 32'h00ff_ffff, 32'h00ff_ffff,
                               32'h00ff_ffff, 32'hffff_ffff};
      rdchk("line command reset", 16'hb100, 32'h7800_0000);
      for (int i = 0; i < 7; i++)
      begin
         wr(adr[i], 32'hffff_ffff);
         rdchk("register field mask", adr[i], msk[i]);
      end
      rdchk("stride second offset", 16'hb4e8, 32'h0000_0ff8);
      `CHK("depth_stride_o", 12'hff8, depth_stride_o)
      `CHK("texture_base_o", 22'h3f_fff8, texture_base_o)
      wr(16'hb230, 32'h1234_5678);
      rdchk("unmapped read", 16'hb230, 32'h0);
   endtask

   task automatic direct_launch();
      logic [31:0] c;
      c = cmd(4'h8, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'b11);
      wr(16'hb100, c);
      launch_chk(1'b1, 1'b1);
      `CHK("dimension_select", 1'b1, active_cfg_o.dimension_select)
      `CHK("draw_command", 4'h8, active_cfg_o.draw_command)
      `CHK("clip_enable_o", 1'b1, clip_enable_o)
      `CHK("alpha_blend_enable_o", 1'b1, alpha_blend_enable_o)
      `CHK("alpha_use_source_o", 1'b1, alpha_use_source_o)
      rdchk("command while busy", 16'hb100, c | 32'h8000_0000);
      @(posedge clk);
      engine_done <= 1'b1;
      @(posedge clk);
      engine_done <= 1'b0;
      rdchk("command when idle", 16'hb100, c);
      wr(16'hb100, cmd(4'h8, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b10));
      launch_chk(1'b1, 1'b1);
      `CHK("clip_enable_o", 1'b0, clip_enable_o)
      `CHK("alpha_use_source_o", 1'b0, alpha_use_source_o)
   endtask

   task automatic auto_exec();
      wr(16'hb500, cmd(4'h0, 3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 2'b00));
      launch_chk(1'b0, 1'b0);
      wr(16'hb57c, 32'h0000_0001);
      launch_chk(1'b1, 1'b0);
      wr(16'hb57c, 32'h0000_0002);
      launch_chk(1'b1, 1'b0);
      wr(16'hb500, 32'h7800_0000);
      launch_chk(1'b0, 1'b0);
      wr(16'hb57c, 32'h0000_0003);
      launch_chk(1'b0, 1'b0);
      wr(16'hb500, cmd(4'h3, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00));
      launch_chk(1'b0, 1'b0);
      rdchk("status after reserved code", 16'hb0f8, 32'h0000_0003);
      wr(16'hb0f8, 32'h0000_0002);
      rdchk("status after clear", 16'hb0f8, 32'h0000_0001);
      wr(16'hb100, cmd(4'h8, 3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 2'b00));
      launch_chk(1'b0, 1'b0);
      wr(16'hb17c, 32'hffff_ffff);
      launch_chk(1'b1, 1'b1);
      `CHK("line_count_o", 11'h7ff, line_count_o)
      `CHK("line_dir_o", 1'b1, line_dir_o)
      rdchk("scan-line count", 16'hb17c, 32'h8000_07ff);
   endtask

   task automatic depth_modes();
      logic [15:0] zs;
      for (int c = 0; c < 8; c++)
      begin
         wr(16'hb500, cmd(4'h1, c[2:0], 1'b1, 1'b0, 1'b0, 1'b0, 2'b00));
         launch_chk(1'b1, 1'b0);
         for (int k = 0; k < 3; k++)
         begin
            zs = 16'h0004 + 16'(k);
            pix(1'b0, 24'h0, 8'h00, zs, 16'h0005);
            `CHK("depth_pass_o", zpass(c[2:0], zs, 16'h0005), depth_pass_o)
            `CHK("depth_write_o", zpass(c[2:0], zs, 16'h0005), depth_write_o)
         end
      end
      wr(16'hb500, cmd(4'h1, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00));
      launch_chk(1'b1, 1'b0);
      pix(1'b0, 24'h0, 8'h00, 16'h0009, 16'h0002);
      `CHK("depth_write_o", 1'b0, depth_write_o)
   endtask

   task automatic fog_border();
      logic [23:0] e;
      wr(16'hb0f4, 32'h0020_4080);
      wr(16'hb4f0, 32'h00c0_6010);
      wr(16'hb500, cmd(4'h1, 3'h7, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00));
      launch_chk(1'b1, 1'b0);
      pix(1'b1, 24'h77_7777, 8'h80, 16'h0, 16'h0);
      e = {fogc(8'hc0, 8'h20, 8'h80), fogc(8'h60, 8'h40, 8'h80), fogc(8'h10, 8'h80, 8'h80)};
      `CHK("colour_o", e, colour_o)
      pix(1'b0, 24'h12_3456, 8'h40, 16'h0, 16'h0);
      e = {fogc(8'h12, 8'h20, 8'h40), fogc(8'h34, 8'h40, 8'h40), fogc(8'h56, 8'h80, 8'h40)};
      `CHK("colour_o", e, colour_o)
   endtask

   task automatic texel_paths();
      logic [31:0] c;
      c = cmd(4'h1, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      wr(16'hb4f8, 32'h0010_2030);
      wr(16'hb4fc, 32'h0050_6070);
      blend_weight_i <= 4'h4;
      pixel_rgb_i <= 24'h80_2001;
      wr(16'hb500, cmd(4'h1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 2'b00) | 32'h0300_0060);
      launch_chk(1'b1, 1'b0);
      pix(1'b0, 24'h70_40ff, 8'h00, 16'h0, 16'h0);
      `CHK("colour_o", 24'h20_3040, colour_o)
      `CHK("depth_pass_o", 1'b1, depth_pass_o)
      `CHK("depth_write_o", 1'b0, depth_write_o)
      wr(16'hb500, c);
      launch_chk(1'b1, 1'b0);
      pix(1'b1, 24'h70_40ff, 8'h00, 16'h0, 16'h0);
      `CHK("colour_o", 24'hc0_6010, colour_o)
      wr(16'hb500, c ^ 32'h0001_8000);
      launch_chk(1'b1, 1'b0);
      pix(1'b0, 24'h70_40ff, 8'h00, 16'h0, 16'h0);
      `CHK("colour_o", 24'h38_0800, colour_o)
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      rst_n = 1'b0;
      wb_req = '0;
      engine_done = 1'b0;
      pix_valid_i = 1'b0;
      texel_rgb_i = 24'h0;
      texel_outside_i = 1'b0;
      blend_weight_i = 4'h0;
      pixel_rgb_i = 24'h0;
      source_alpha_i = 8'h00;
      zs_i = 16'h0;
      zzb_i = 16'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      masks();
      direct_launch();
      auto_exec();
      depth_modes();
      fog_border();
      texel_paths();
      complete_run();
   end
endmodule
`default_nettype wire
